// File: verilog/ruc_pkg.sv
// Functional notes
// - update writes by user, factory image only
// - remote errors zero control; factory trigger loads update
// - local reset/trigger selects page one, anf
// - status records cause before reload
// - reads show update (factory) or control
// - watchdog is 29-bit down-counter from control
// - only top 12 watchdog bits programmable
// - low 17 count bits forced zero
// - watchdog steps on oscillator tick
// - watchdog counts only in application user mode
// - reload falling edge restores start count
// - expiry sets watchdog cause, loads factory
// - watchdog off in configuration and factory
// - reload honoured only remote application images
// - other fabric signals work in all modes except update
// - shift-to-update only factory in remote mode
// - low request reconfigures per mode and image
// - shift clock drives shift and update registers
// - shift select high shifts left each rising edge
// - shift low: capture high loads, low updates
package ruc_pkg;
   // ==========================================================
   // timing
   localparam int CLK_HZ      = 100_000_000;
   localparam int OSC_HZ      = 10_000_000;
   localparam int OSC_DIV     = CLK_HZ / OSC_HZ;
   localparam int OSC_CNT_W   = 4;
   localparam int CFG_TIME_NS = 2000;
   localparam int CFG_CYCLES  =
      (CFG_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CFG_CNT_W   = 8;
   // ==========================================================
   // register geometry
   localparam int WDOG_W   = 29;
   localparam int WDT_W    = 12;
   localparam int WD_LOW_W = 17;
   localparam int CTRL_W   = 21;
   localparam int STAT_W   = 5;
   localparam int SR_W     = STAT_W + CTRL_W;
   localparam logic [6:0] LOCAL_PAGE = 7'h01;
   // ==========================================================
   // bus map
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_MODE    = 8'h00;
   localparam logic [7:0] OFS_EVENT   = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_UPDATE  = 8'h0c;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_WDOG    = 8'h14;
   localparam int EVT_EXT = 0;
   localparam int EVT_STS = 1;
   localparam int EVT_CRC = 2;
   localparam int EVT_W   = 3;
   localparam int MODE_REMOTE_BIT = 0;
   localparam logic MODE_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // types
   typedef struct packed {
      logic [11:0] watchdog_timeout_field;
      logic        wd_en;
      logic [6:0]  page;
      logic        anf;
   } ruc_ctrl_s;
   typedef struct packed {
      logic wd;
      logic ext_reset;
      logic fabric;
      logic status_err;
      logic crc;
   } ruc_stat_s;
   typedef struct packed {
      logic shift_clock;
      logic shift_sel;
      logic capt_sel;
      logic din;
      logic reconfig_n;
      logic reload_n;
   } ruc_pins_s;
   localparam logic [5:0] PINS_IDLE = 6'h03;
   typedef enum logic [1:0] {
      ST_CONFIG = 2'b00,
      ST_USER   = 2'b01,
      ST_REQ    = 2'b10
   } ruc_state_e;
endpackage

// File: verilog/ruc_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser; only stage two is visible
module ruc_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ruc_sync_s;
   ruc_sync_s r_reg, r_next;
   // ==========================================================
   // stages
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_reg <= {RST_VAL, RST_VAL};
      end else begin
         r_reg <= r_next;
      end
   end
   assign q = r_reg.s2;
endmodule

// File: verilog/ruc_wdog.sv
`timescale 1ns/100ps
// user watchdog down-counter
module ruc_wdog #(
   parameter int W = ruc_pkg::WDOG_W
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         enable,
   input  wire logic         tick,
   input  wire logic         reload,
   input  wire logic [W-1:0] start,
   output logic              expired,
   output logic      [W-1:0] count
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         exp;
   } ruc_wdog_s;
   ruc_wdog_s r_reg, r_next;
   // ==========================================================
   // counter: held at start while disabled, so enable starts clean
   always_comb begin
      r_next     = r_reg;
      r_next.exp = 1'b0;
      if (!enable || reload) begin
         r_next.cnt = start;
      end else if (tick) begin
         if (r_reg.cnt == '0) begin
            r_next.exp = 1'b1;
            r_next.cnt = start;
         end else begin
            r_next.cnt = r_reg.cnt - 1'b1;
         end
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign expired = r_reg.exp;
   assign count   = r_reg.cnt;
   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_wd_reload;
      enable && reload |=> count == $past(start);
   endproperty
   a_wd_reload: assert property (p_wd_reload)
      else $error("reload did not restore start count");
   property p_wd_tick_only;
      enable && !reload && !tick |=> $stable(count);
   endproperty
   a_wd_tick_only: assert property (p_wd_tick_only)
      else $error("watchdog moved without oscillator tick");
   property p_wd_off;
      !enable |=> count == $past(start) && !expired;
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("disabled watchdog counted or expired");
   c_wd_expire: cover property (expired);
endmodule

// File: verilog/ruc_top.sv
`timescale 1ns/100ps
// remote update controller: shift interface, image selection,
// watchdog and an axi4-lite register window
module ruc_top (
   input  wire logic                         clock,
   input  wire logic                         rst,
   // axi4-lite slave
   input  wire logic [ruc_pkg::ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [ruc_pkg::ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   // fabric side
   input  wire logic                         fabric_reconfig_request_n,
   input  wire logic                         watchdog_reload_n,
   input  wire logic                         upgrade_shift_clock,
   input  wire logic                         shift_or_load_select,
   input  wire logic                         capture_or_update_select,
   input  wire logic                         shift_serial_in,
   output logic                              shift_serial_out,
   // image state
   output logic                              reconfig_busy,
   output logic                              application_image
);
   typedef struct packed {
      ruc_pkg::ruc_state_e            st;
      logic                           remote;
      ruc_pkg::ruc_ctrl_s             ctrl;
      ruc_pkg::ruc_ctrl_s             upd;
      ruc_pkg::ruc_stat_s             stat;
      logic [ruc_pkg::SR_W-1:0]       sr;
      logic [ruc_pkg::CFG_CNT_W-1:0]  cfg_cnt;
      logic [ruc_pkg::OSC_CNT_W-1:0]  osc_cnt;
      logic                           sclk_q;
      logic                           req_q;
      logic                           rld_q;
      logic                           aw_have;
      logic [ruc_pkg::ADDR_W-1:0]     awaddr;
      logic                           w_have;
      logic [31:0]                    wdata;
      logic                           wstrb0;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
   } ruc_top_s;
   ruc_top_s r_reg, r_next;
   ruc_pkg::ruc_pins_s             pins;
   logic                           tick;
   logic                           wd_enable;
   logic                           wd_reload;
   logic                           wd_expired;
   logic [ruc_pkg::WDOG_W-1:0]     wd_start;
   logic [ruc_pkg::WDOG_W-1:0]     wd_count;
   logic                           sedge;
   // ==========================================================
   // pin synchronisers
   ruc_sync #(
      .W       ($bits(ruc_pkg::ruc_pins_s)),
      .RST_VAL (ruc_pkg::PINS_IDLE)
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({upgrade_shift_clock, shift_or_load_select,
               capture_or_update_select, shift_serial_in,
               fabric_reconfig_request_n, watchdog_reload_n}),
      .q     (pins)
   );
   // ==========================================================
   // watchdog
   // oscillator rate is a divided enable, not a second clock
   assign tick      = (r_reg.osc_cnt ==
                       ruc_pkg::OSC_CNT_W'(ruc_pkg::OSC_DIV - 1));
   assign wd_enable = (r_reg.st == ruc_pkg::ST_USER) && r_reg.remote
                      && r_reg.ctrl.anf && r_reg.ctrl.wd_en;
   assign wd_reload = wd_enable && r_reg.rld_q && !pins.reload_n;
   assign wd_start  = {r_reg.ctrl.watchdog_timeout_field,
                       {ruc_pkg::WD_LOW_W{1'b0}}};
   ruc_wdog #(
      .W (ruc_pkg::WDOG_W)
   ) u_wdog (
      .clock   (clock),
      .rst     (rst),
      .enable  (wd_enable),
      .tick    (tick),
      .reload  (wd_reload),
      .start   (wd_start),
      .expired (wd_expired),
      .count   (wd_count)
   );
   assign sedge = pins.shift_clock && !r_reg.sclk_q;
   // ==========================================================
   // next state
   always_comb begin
      logic [ruc_pkg::EVT_W-1:0] evt;
      logic                      go;
      ruc_pkg::ruc_stat_s        cause;
      ruc_pkg::ruc_ctrl_s        nctl;
      ruc_pkg::ruc_ctrl_s        lp;
      evt   = '0;
      go    = 1'b0;
      cause = '0;
      nctl  = r_reg.ctrl;
      lp    = '0;
      lp.page = ruc_pkg::LOCAL_PAGE;
      lp.anf  = 1'b1;
      r_next  = r_reg;
      r_next.sclk_q = pins.shift_clock;
      r_next.req_q  = pins.reconfig_n;
      r_next.rld_q  = pins.reload_n;
      r_next.osc_cnt = tick ? '0 : r_reg.osc_cnt + 1'b1;
      // bus write: address and data taken in either order
      if (!r_reg.aw_have && s_axi_awvalid) begin
         r_next.aw_have = 1'b1;
         r_next.awaddr  = s_axi_awaddr;
      end
      if (!r_reg.w_have && s_axi_wvalid) begin
         r_next.w_have = 1'b1;
         r_next.wdata  = s_axi_wdata;
         r_next.wstrb0 = s_axi_wstrb[0];
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
         r_next.aw_have = 1'b0;
         r_next.w_have  = 1'b0;
         r_next.bvalid  = 1'b1;
         r_next.bresp   = ruc_pkg::RESP_OKAY;
         if (r_reg.awaddr == ruc_pkg::OFS_MODE) begin
            if (r_reg.wstrb0) begin
               r_next.remote = r_reg.wdata[ruc_pkg::MODE_REMOTE_BIT];
            end
         end else if (r_reg.awaddr == ruc_pkg::OFS_EVENT) begin
            if (r_reg.wstrb0) begin
               evt = r_reg.wdata[ruc_pkg::EVT_W-1:0];
            end
         end else if (r_reg.awaddr == ruc_pkg::OFS_CONTROL ||
                      r_reg.awaddr == ruc_pkg::OFS_UPDATE ||
                      r_reg.awaddr == ruc_pkg::OFS_STATUS ||
                      r_reg.awaddr == ruc_pkg::OFS_WDOG) begin
            r_next.bresp = ruc_pkg::RESP_OKAY; // read-only, ignored
         end else begin
            r_next.bresp = ruc_pkg::RESP_SLVERR;
         end
      end
      // bus read
      if (r_reg.rvalid) begin
         if (s_axi_rready) begin
            r_next.rvalid = 1'b0;
         end
      end else if (s_axi_arvalid) begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = ruc_pkg::RESP_OKAY;
         if (s_axi_araddr == ruc_pkg::OFS_MODE) begin
            r_next.rdata = 32'(r_reg.remote);
         end else if (s_axi_araddr == ruc_pkg::OFS_EVENT) begin
            r_next.rdata = '0;
         end else if (s_axi_araddr == ruc_pkg::OFS_CONTROL) begin
            r_next.rdata = 32'(r_reg.ctrl);
         end else if (s_axi_araddr == ruc_pkg::OFS_UPDATE) begin
            r_next.rdata = 32'(r_reg.upd);
         end else if (s_axi_araddr == ruc_pkg::OFS_STATUS) begin
            r_next.rdata = 32'({r_reg.st, r_reg.stat});
         end else if (s_axi_araddr == ruc_pkg::OFS_WDOG) begin
            r_next.rdata = 32'(wd_count);
         end else begin
            r_next.rdata = '0;
            r_next.rresp = ruc_pkg::RESP_SLVERR;
         end
      end
      // reconfiguration causes, highest priority first
      if (evt[ruc_pkg::EVT_EXT]) begin
         go = 1'b1;
         cause.ext_reset = 1'b1;
         nctl = r_reg.remote ? '0 : lp;
      end else if (evt[ruc_pkg::EVT_STS]) begin
         go = 1'b1;
         cause.status_err = 1'b1;
         nctl = '0;
      end else if (evt[ruc_pkg::EVT_CRC]) begin
         go = 1'b1;
         cause.crc = 1'b1;
         nctl = '0;
      end else if (wd_expired) begin
         go = 1'b1;
         cause.wd = 1'b1;
         nctl = '0;
      end else if (r_reg.st == ruc_pkg::ST_USER && r_reg.req_q &&
                   !pins.reconfig_n) begin
         if (r_reg.remote && !r_reg.ctrl.anf) begin
            r_next.st = ruc_pkg::ST_REQ;               // wait release
         end else begin
            go = 1'b1;
            cause.fabric = 1'b1;
            nctl = r_reg.remote ? '0 : lp;
         end
      end else if (r_reg.st == ruc_pkg::ST_REQ && pins.reconfig_n) begin
         go = 1'b1;
         cause.fabric = 1'b1;
         nctl = r_reg.upd;
      end
      // status is written together with control, before reload
      if (go) begin
         r_next.ctrl    = nctl;
         r_next.stat    = cause;
         r_next.st      = ruc_pkg::ST_CONFIG;
         r_next.cfg_cnt = '0;
      end else if (r_reg.st == ruc_pkg::ST_CONFIG) begin
         if (r_reg.cfg_cnt ==
             ruc_pkg::CFG_CNT_W'(ruc_pkg::CFG_CYCLES - 1)) begin
            r_next.st = ruc_pkg::ST_USER;
         end else begin
            r_next.cfg_cnt = r_reg.cfg_cnt + 1'b1;
         end
      end
      // shift interface, sampled edges of the fabric shift clock
      if (sedge) begin
         if (pins.shift_sel) begin
            r_next.sr = {r_reg.sr[ruc_pkg::SR_W-2:0], pins.din};
         end else if (pins.capt_sel) begin
            r_next.sr = {r_reg.stat,
                         r_reg.ctrl.anf ? r_reg.ctrl : r_reg.upd};
         end else if (r_reg.remote && !r_reg.ctrl.anf) begin
            r_next.upd = r_reg.sr[ruc_pkg::CTRL_W-1:0];
         end
      end
   end
   // ==========================================================
   // state register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         r_reg        <= '0;
         r_reg.remote <= ruc_pkg::MODE_RESET;
         r_reg.st     <= ruc_pkg::ST_CONFIG;
         r_reg.sclk_q <= 1'b0;
         r_reg.req_q  <= 1'b1;
         r_reg.rld_q  <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end
   // ==========================================================
   // outputs
   assign s_axi_awready     = !r_reg.aw_have;
   assign s_axi_wready      = !r_reg.w_have;
   assign s_axi_bvalid      = r_reg.bvalid;
   assign s_axi_bresp       = r_reg.bresp;
   assign s_axi_arready     = !r_reg.rvalid;
   assign s_axi_rvalid      = r_reg.rvalid;
   assign s_axi_rdata       = r_reg.rdata;
   assign s_axi_rresp       = r_reg.rresp;
   assign shift_serial_out  = r_reg.sr[ruc_pkg::SR_W-1];
   assign reconfig_busy     = (r_reg.st != ruc_pkg::ST_USER);
   assign application_image = r_reg.ctrl.anf;
   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_upd_factory;
      !$stable(r_reg.upd) |-> $past(!r_reg.ctrl.anf) && $past(r_reg.remote);
   endproperty
   a_upd_factory: assert property (p_upd_factory)
      else $error("update register written outside factory remote");
   property p_shift;
      sedge && pins.shift_sel |=>
         r_reg.sr == {$past(r_reg.sr[ruc_pkg::SR_W-2:0]), $past(pins.din)};
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift register did not move left");
   property p_capture;
      sedge && !pins.shift_sel && pins.capt_sel && r_reg.ctrl.anf |=>
         r_reg.sr[ruc_pkg::CTRL_W-1:0] == $past(r_reg.ctrl);
   endproperty
   a_capture: assert property (p_capture)
      else $error("application capture did not load control");
   property p_remote_err;
      r_reg.st == ruc_pkg::ST_USER && wd_expired |=>
         r_reg.ctrl == '0 && r_reg.stat.wd &&
         r_reg.st == ruc_pkg::ST_CONFIG;
   endproperty
   a_remote_err: assert property (p_remote_err)
      else $error("watchdog expiry did not select factory");
   property p_release_copy;
      r_reg.st == ruc_pkg::ST_REQ && pins.reconfig_n &&
      r_next.stat.fabric |=> r_reg.ctrl == $past(r_reg.upd);
   endproperty
   a_release_copy: assert property (p_release_copy)
      else $error("release did not copy update into control");
   property p_wd_config_off;
      r_reg.st == ruc_pkg::ST_CONFIG || !r_reg.ctrl.anf |-> !wd_enable;
   endproperty
   a_wd_config_off: assert property (p_wd_config_off)
      else $error("watchdog enabled in configuration or factory");
   property p_local_off;
      !r_reg.remote |-> !wd_enable;
   endproperty
   a_local_off: assert property (p_local_off)
      else $error("watchdog enabled in local mode");
   property p_cause_once;
      r_next.st == ruc_pkg::ST_CONFIG && r_reg.st != ruc_pkg::ST_CONFIG
      |=> $onehot(r_reg.stat);
   endproperty
   a_cause_once: assert property (p_cause_once)
      else $error("status does not hold a single cause");
   c_reconfig: cover property (r_reg.st == ruc_pkg::ST_REQ ##[1:50]
                               r_reg.st == ruc_pkg::ST_CONFIG);
   c_update: cover property (sedge && !pins.shift_sel && !pins.capt_sel);
   c_wd_trip: cover property (wd_expired);
endmodule

// File: bench/ruc_fabric_model.sv
`timescale 1ns/100ps
// ==========================================================
// fabric user logic on the far side of the shift link
module ruc_fabric_model (
   output logic      upgrade_shift_clock,
   output logic      shift_or_load_select,
   output logic      capture_or_update_select,
   output logic      shift_serial_in,
   input  wire logic shift_serial_out
);
   // link clock parked low between frames
   initial begin
      upgrade_shift_clock = 1'b0;
      shift_or_load_select = 1'b1;
      capture_or_update_select = 1'b1;
      shift_serial_in = 1'b0;
   end
   // one link edge; selects held across it, output taken just before
   task automatic step(input logic s, input logic c, input logic d,
                       output logic q);
      shift_or_load_select = s;
      capture_or_update_select = c;
      shift_serial_in = d;
      #39 q = shift_serial_out;
      #1 upgrade_shift_clock = 1'b1;
      #40 upgrade_shift_clock = 1'b0;
   endtask
   // capture, 26 shifts msb first, then an optional update
   task automatic xfer(input logic [25:0] wr, input logic upd,
                       output logic [25:0] rd);
      logic q;
      #3 step(1'b0, 1'b1, ~shift_serial_in, q);
      for (int i = 25; i >= 0; i--) step(1'b1, 1'b0, wr[i], rd[i]);
      if (upd) step(1'b0, 1'b0, ~wr[0], q);
      // data line not left at its last value
      shift_serial_in = ~shift_serial_in;
   endtask
endmodule

// File: bench/remote_update_controller_tb.sv
`timescale 1ns/100ps
module remote_update_controller_tb;
   // ==========================================================
   // stimulus and observed signals
   logic        clock = 1'b0, rst = 1'b1, req_n = 1'b1, reload_n = 1'b1;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d, c1;
   logic        awready, wready, bvalid, arready, rvalid, busy, app;
   logic        sck, ssel, csel, sdin, sdout;
   logic [1:0]  bresp, rresp, r;
   logic [25:0] sr;
   int          fail_count = 0, tests_run = 0;

   ruc_top dut (
      .clock(clock), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fabric_reconfig_request_n(req_n), .watchdog_reload_n(reload_n),
      .upgrade_shift_clock(sck), .shift_or_load_select(ssel),
      .capture_or_update_select(csel), .shift_serial_in(sdin),
      .shift_serial_out(sdout), .reconfig_busy(busy),
      .application_image(app));

   ruc_fabric_model fab (
      .upgrade_shift_clock(sck), .shift_or_load_select(ssel),
      .capture_or_update_select(csel), .shift_serial_in(sdin),
      .shift_serial_out(sdout));

   always #5 clock = ~clock;

   // ==========================================================
   // checking and bus tasks
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input string n);
      logic [31:0] v;
      logic [1:0]  rs;
      rd(a, v, rs);
      chk(n, e, v);
   endtask
   // bounded wait for a configuration cycle to start and end
   task automatic reconf();
      int n;
      for (n = 0; n < 30 && busy !== 1'b1; n++) @(posedge clock);
      chk("busy rose", 1, busy);
      for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clock);
      chk("busy fell", 0, busy);
   endtask
   task automatic pulse_req();
      req_n <= 1'b0;
      repeat (20) @(posedge clock);
      req_n <= 1'b1;
   endtask
   task automatic wrap_up();
      $display("mismatches %0d of %0d checks", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard, far beyond the ~3000 cycles of the sequence
   initial begin
      #200000;
      fail_count++;
      wrap_up();
   end

   // ==========================================================
   // test sequence
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      chk("image in reset", 0, app);
      reconf();
      rc(ruc_pkg::OFS_MODE, 1, "mode");
      fab.xfer(26'h30b, 1'b1, sr);
      chk("capture factory", 0, sr);
      rc(ruc_pkg::OFS_UPDATE, 32'h30b, "update");
      rc(ruc_pkg::OFS_CONTROL, 0, "control locked");
      fab.xfer(26'h0, 1'b0, sr);
      chk("factory readback", 32'h30b, sr);
      req_n <= 1'b0;
      repeat (20) @(posedge clock);
      chk("held while low", 1, busy);
      rc(ruc_pkg::OFS_STATUS, 32'h40, "request state");
      req_n <= 1'b1;
      reconf();
      chk("application", 1, app);
      rc(ruc_pkg::OFS_CONTROL, 32'h30b, "control copied");
      rc(ruc_pkg::OFS_STATUS, 32'h24, "fabric cause");
      fab.xfer(26'h0, 1'b1, sr);
      chk("app readback", 32'h80030b, sr);
      rc(ruc_pkg::OFS_UPDATE, 32'h30b, "app no update");
      rd(ruc_pkg::OFS_WDOG, c1, r);
      chk("wdog start", 1, c1 <= 32'h20000 && c1 > 32'h1fe00);
      repeat (100) @(posedge clock);
      rd(ruc_pkg::OFS_WDOG, d, r);
      chk("wdog rate", 1, c1 - d >= 10 && c1 - d <= 12);
      reload_n <= 1'b0;
      repeat (6) @(posedge clock);
      reload_n <= 1'b1;
      rd(ruc_pkg::OFS_WDOG, d, r);
      chk("wdog reload", 1, d <= 32'h20000 && d >= 32'h1fffd);
      wr(ruc_pkg::OFS_EVENT, 32'h1, r);
      chk("event bresp", ruc_pkg::RESP_OKAY, r);
      reconf();
      chk("factory again", 0, app);
      rc(ruc_pkg::OFS_CONTROL, 0, "control cleared");
      rc(ruc_pkg::OFS_STATUS, 32'h28, "ext cause");
      rd(ruc_pkg::OFS_WDOG, c1, r);
      repeat (50) @(posedge clock);
      rc(ruc_pkg::OFS_WDOG, c1, "wdog idle");
      rd(8'h3c, d, r);
      chk("unmapped rresp", ruc_pkg::RESP_SLVERR, r);
      chk("unmapped rdata", 0, d);
      wr(8'h3c, 32'h1, r);
      chk("unmapped bresp", ruc_pkg::RESP_SLVERR, r);
      // zero timeout with enable set: application trips at first tick
      fab.xfer(26'h103, 1'b1, sr);
      chk("factory status capture", 32'h100030b, sr);
      pulse_req();
      reconf();
      chk("wdog app", 1, app);
      reconf();
      rc(ruc_pkg::OFS_STATUS, 32'h30, "wdog cause");
      rc(ruc_pkg::OFS_CONTROL, 0, "wdog cleared");
      // local update mode from here on
      wr(ruc_pkg::OFS_MODE, 32'h0, r);
      fab.xfer(26'h1, 1'b1, sr);
      rc(ruc_pkg::OFS_UPDATE, 32'h103, "local no update");
      pulse_req();
      reconf();
      chk("local app", 1, app);
      rc(ruc_pkg::OFS_CONTROL, 32'h3, "local page");
      wr(ruc_pkg::OFS_EVENT, 32'h2, r);
      reconf();
      rc(ruc_pkg::OFS_CONTROL, 0, "status err");
      rc(ruc_pkg::OFS_STATUS, 32'h22, "status cause");
      wr(ruc_pkg::OFS_EVENT, 32'h4, r);
      reconf();
      rc(ruc_pkg::OFS_STATUS, 32'h21, "crc cause");
      wrap_up();
   end
endmodule
